// ---- hw/fpsc_cfg.svh ----
/*
 Constants of the front panel settings controller: register offsets,
 field positions, reset values and timing counts.
 Assumes a 25 MHz system clock.
*/
`ifndef FPSC_CFG_SVH
`define FPSC_CFG_SVH

// =====================================================================
// Timing
`define CLK_HZ            25000000
`define EDIT_TIMEOUT_S    30
`define EDIT_TIMEOUT_CYC  (`EDIT_TIMEOUT_S * `CLK_HZ)
`define PHASE_MS          1000
`define PHASE_CYC         (`PHASE_MS * (`CLK_HZ / 1000))
`define BAUD              9600
`define BAUD_CYC          (`CLK_HZ / `BAUD)

// =====================================================================
// Register byte offsets
`define OFS_STATUS        8'h00
`define OFS_GAIN          8'h04
`define OFS_CONTROL       8'h08
`define OFS_OFFSET        8'h0C
`define OFS_BUSADDR       8'h10
`define OFS_UART          8'h14

// =====================================================================
// Control register fields
`define CTL_MUTE          0
`define CTL_REFMODE_LO    1
`define CTL_REFMODE_HI    2
`define CTL_REMOTE        3
`define CTL_IFACE         4

// =====================================================================
// Setting limits and reset values (gain in 0.5 dB units)
`define GAIN_MIN          7'h0A
`define GAIN_MAX          7'h46
`define OFFSET_LIMIT      13'sh07D0
`define RST_GAIN          7'h28
`define RST_REFMODE       2'h0
`define RST_OFFSET        12'h000
`define RST_ADDR          5'h00
`define ADDR_MAX          5'h1F
`define MENU_LAST         3'h7
`define CUR_RET           3'h4
`define REFMODE_LAST      2'h2

`endif

// ---- hw/fpsc_pkg.sv ----
/*
 Types shared by the settings controller and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fpsc_pkg;

	typedef enum logic [2:0] {
		ST_PU_SEGMENTS = 3'b000,
		ST_PU_MODEL    = 3'b001,
		ST_PU_STATUS   = 3'b010,
		ST_NORMAL      = 3'b011,
		ST_EDIT        = 3'b100,
		ST_SAVE        = 3'b101
	} ctrl_state_type;

	typedef enum logic [1:0] {
		REF_INT  = 2'b00,
		REF_EXT  = 2'b01,
		REF_AUTO = 2'b10
	} ref_mode_type;

	typedef enum logic [2:0] {
		IND_INT    = 3'b000,
		IND_EXT    = 3'b001,
		IND_AUTO_E = 3'b010,
		IND_AUTO_I = 3'b011
	} ref_ind_type;

	typedef enum logic [3:0] {
		PG_STATUS  = 4'h0,
		PG_GAIN    = 4'h1,
		PG_MUTE    = 4'h2,
		PG_REFMODE = 4'h3,
		PG_OFFSET  = 4'h4,
		PG_REMOTE  = 4'h5,
		PG_IFACE   = 4'h6,
		PG_ADDR    = 4'h7,
		PG_SAVE    = 4'h8,
		PG_ALL_ON  = 4'h9,
		PG_MODEL   = 4'hA
	} disp_page_type;

	typedef struct packed {
		logic [6:0]  gain;
		logic        mute;
		logic [1:0]  ref_mode;
		logic [11:0] offset;
		logic        remote;
		logic        iface;
		logic [4:0]  addr;
	} settings_type;

endpackage

// ---- hw/pin_sync.sv ----
/*
 Three-stage synchroniser for pins; a level is accepted once the
 second and third stages agree, and a rising change gives a pulse.
 Assumes raw inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] raw,
	output var  logic [WIDTH-1:0] level,
	output var  logic [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] agree;

	// =================================================================
	// Stages; s1 feeds only s2 so metastability stays contained
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else if (ce) begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign agree = ~(s2_reg ^ s3_reg);

	// Accepted level and one-cycle rise pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level <= '0;
			rise  <= '0;
		end else if (ce) begin
			level <= (s2_reg & agree) | (level & ~agree);
			rise  <= s2_reg & agree & ~level;
		end
	end

endmodule
`default_nettype wire

// ---- hw/serial_tx.sv ----
/*
 Serial transmitter, one start bit, eight data bits LSB first,
 no parity, one stop bit.
 Assumes start is only pulsed while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_cfg.svh"

module serial_tx (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       start,
	input  wire logic [7:0] data,
	output var  logic       txd,
	output var  logic       busy
);

	localparam logic [11:0] BIT_CYC = 12'(`BAUD_CYC);

	logic [11:0] baud_cnt_reg;
	logic [3:0]  bits_left_reg;
	logic [9:0]  shift_reg;

	// =================================================================
	// Frame shifter; the line idles high between frames
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			baud_cnt_reg  <= 12'h000;
			bits_left_reg <= 4'h0;
			shift_reg     <= 10'h3FF;
			txd           <= 1'b1;
			busy          <= 1'b0;
		end else if (ce) begin
			if (!busy && start) begin
				shift_reg     <= {1'b1, data, 1'b0};
				bits_left_reg <= 4'hA;
				baud_cnt_reg  <= 12'h000;
				busy          <= 1'b1;
				txd           <= 1'b0;
			end else if (busy) begin
				if (baud_cnt_reg == BIT_CYC - 12'h001) begin
					baud_cnt_reg  <= 12'h000;
					bits_left_reg <= bits_left_reg - 4'h1;
					shift_reg     <= {1'b1, shift_reg[9:1]};
					txd           <= shift_reg[1];
					if (bits_left_reg == 4'h1) begin
						busy <= 1'b0;
						txd  <= 1'b1;
					end
				end else begin
					baud_cnt_reg <= baud_cnt_reg + 12'h001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- hw/panel_ctrl.sv ----
/*
 Front panel settings controller of a block downconverter: menu,
 edit and save sequence, edit timeout, power-up display steps,
 retained settings, reference selection, alarm and register port.
 Assumes switches, lock and level detector pins are asynchronous,
 a non-volatile store outside that presents its image at reset and
 takes a new one on a store pulse, and one 25 MHz clock.

*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_cfg.svh"

module panel_ctrl #(
	parameter int unsigned TIMEOUT_CYCLES = `EDIT_TIMEOUT_CYC,
	parameter int unsigned PHASE_CYCLES   = `PHASE_CYC
) (
	input  wire logic                    CLK,
	input  wire logic                    RESET,
	input  wire logic                    CE,
	input  wire logic                    MENU_SW,
	input  wire logic                    LEFT_SW,
	input  wire logic                    RIGHT_SW,
	input  wire logic                    UP_SW,
	input  wire logic                    DOWN_SW,
	input  wire logic [1:0]              PLL_LOCK,
	input  wire logic                    REF_LVL_OK,
	input  wire logic                    REF_LVL_LOW,
	input  wire logic [31:0]             NV_IN,
	input  wire logic                    NV_IN_VALID,
	input  wire logic [7:0]              ADDR,
	input  wire logic [31:0]             WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output var  logic [31:0]             RDATA,
	output var  logic [31:0]             NV_OUT,
	output var  logic                    NV_STORE,
	output var  logic [6:0]              GAIN,
	output var  logic                    MUTE,
	output var  logic [11:0]             REF_OFFSET,
	output var  logic                    REMOTE_IFACE,
	output var  logic [4:0]              BUS_ADDR,
	output var  logic                    REF_USE_EXT,
	output var  logic                    REFERENCE_OUTPUT_CONNECTOR_EXT,
	output var  fpsc_pkg::ref_ind_type   DISP_REF,
	output var  fpsc_pkg::disp_page_type DISP_PAGE,
	output var  logic [2:0]              DISP_CURSOR,
	output var  logic                    DISP_YES,
	output var  logic                    ALARM_INDICATOR_LED,
	output var  logic                    ALARM_RELAY,
	output var  logic                    REMOTE_LED,
	output var  logic                    DC_POWER_INDICATOR_LED,
	output var  logic                    SER_TXD
);
	import fpsc_pkg::*;

	localparam settings_type RST_SETTINGS = '{
		gain: `RST_GAIN, mute: 1'b0, ref_mode: `RST_REFMODE,
		offset: `RST_OFFSET, remote: 1'b0, iface: 1'b0,
		addr: `RST_ADDR};

	// =================================================================
	// Signals
	ctrl_state_type state_reg;
	settings_type   work_reg;
	settings_type   saved_reg;
	settings_type   nv_image;
	logic [29:0]    idle_cnt_reg;
	logic [29:0]    phase_cnt_reg;
	logic [2:0]     menu_reg;
	logic [2:0]     cursor_reg;
	logic           yes_reg;
	logic           loaded_reg;
	logic [8:0]     pin_level;
	logic [8:0]     pin_rise;
	logic           p_menu, p_left, p_right, p_up, p_down, p_vert;
	logic           nv_load;
	logic           timeout_hit;
	logic           commit;
	logic           revert;
	logic           reg_wr;
	logic           tx_start;
	logic           tx_busy;
	logic           any_press;

	// =================================================================
	// Helpers
	function automatic logic [6:0] gain_step(input logic [2:0] pos);
		case (pos)
			3'h0:    gain_step = 7'h14; // 10 dB
			3'h1:    gain_step = 7'h02; // 1 dB
			3'h2:    gain_step = 7'h01; // 0.5 dB
			default: gain_step = 7'h00;
		endcase
	endfunction

	function automatic logic [6:0] bump_gain(input logic [6:0] g,
		input logic [6:0] st, input logic up);
		logic [7:0] t;
		t = 8'h00;
		if (up) begin
			t = {1'b0, g} + {1'b0, st};
			if (t > {1'b0, `GAIN_MAX}) t = {1'b0, `GAIN_MAX};
		end else if (g < `GAIN_MIN + st) begin
			t = {1'b0, `GAIN_MIN};
		end else begin
			t = {1'b0, g - st};
		end
		bump_gain = t[6:0];
	endfunction

	function automatic logic [11:0] bump_offset(input logic [11:0] o,
		input logic [2:0] pos, input logic up);
		logic signed [12:0] st;
		logic signed [12:0] t;
		case (pos)
			3'h0:    st = 13'sh03E8;
			3'h1:    st = 13'sh0064;
			3'h2:    st = 13'sh000A;
			default: st = 13'sh0001;
		endcase
		t = up ? $signed({o[11], o}) + st : $signed({o[11], o}) - st;
		if (t > `OFFSET_LIMIT) t = `OFFSET_LIMIT;
		if (t < -`OFFSET_LIMIT) t = -`OFFSET_LIMIT;
		bump_offset = t[11:0];
	endfunction

	// One vertical-switch action on the item of the current menu
	function automatic settings_type edit_item(input settings_type s,
		input logic [2:0] menu, input logic [2:0] pos, input logic up);
		edit_item = s;
		case (menu)
			3'h1: edit_item.gain = bump_gain(s.gain, gain_step(pos),
				up);
			3'h2: edit_item.mute = ~s.mute;
			3'h3: begin
				if (up) begin
					edit_item.ref_mode = (s.ref_mode >= `REFMODE_LAST) ?
						2'h0 : s.ref_mode + 2'h1;
				end else begin
					edit_item.ref_mode = (s.ref_mode == 2'h0) ?
						`REFMODE_LAST : s.ref_mode - 2'h1;
				end
			end
			3'h4: edit_item.offset = bump_offset(s.offset, pos, up);
			3'h5: edit_item.remote = ~s.remote;
			3'h6: edit_item.iface = ~s.iface;
			3'h7: edit_item.addr = up ? s.addr + 5'h01 : s.addr - 5'h01;
			default: edit_item = s;
		endcase
	endfunction

	// Register write applied to the stored settings
	function automatic settings_type reg_write(input settings_type s,
		input logic [7:0] a, input logic [31:0] d);
		reg_write = s;
		if (a == `OFS_GAIN) begin
			if (d[6:0] >= `GAIN_MIN && d[6:0] <= `GAIN_MAX)
				reg_write.gain = d[6:0];
		end else if (a == `OFS_CONTROL) begin
			reg_write.mute   = d[`CTL_MUTE];
			reg_write.remote = d[`CTL_REMOTE];
			reg_write.iface  = d[`CTL_IFACE];
			if (d[`CTL_REFMODE_HI:`CTL_REFMODE_LO] <= `REFMODE_LAST)
				reg_write.ref_mode =
					d[`CTL_REFMODE_HI:`CTL_REFMODE_LO];
		end else if (a == `OFS_OFFSET) begin
			if ($signed(d[12:0]) <= `OFFSET_LIMIT &&
				$signed(d[12:0]) >= -`OFFSET_LIMIT)
				reg_write.offset = d[11:0];
		end else if (a == `OFS_BUSADDR) begin
			reg_write.addr = d[4:0];
		end
	endfunction

	// =================================================================
	// Pin synchronisers
	pin_sync #(
		.WIDTH (9)
	) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.ce    (CE),
		.raw   ({MENU_SW, LEFT_SW, RIGHT_SW, UP_SW, DOWN_SW,
			PLL_LOCK, REF_LVL_OK, REF_LVL_LOW}),
		.level (pin_level),
		.rise  (pin_rise)
	);

	assign p_menu    = pin_rise[8];
	assign p_left    = pin_rise[7];
	assign p_right   = pin_rise[6];
	assign p_up      = pin_rise[5];
	assign p_down    = pin_rise[4];
	assign p_vert    = p_up | p_down;
	assign any_press = |pin_rise[8:4];

	// =================================================================
	// Sequence events
	assign nv_image    = NV_IN_VALID ? settings_type'(NV_IN[28:0])
		: RST_SETTINGS;
	assign nv_load     = (state_reg == ST_PU_SEGMENTS) && !loaded_reg;
	assign timeout_hit = ((state_reg == ST_EDIT) ||
		(state_reg == ST_SAVE)) && !any_press &&
		(idle_cnt_reg == 30'(TIMEOUT_CYCLES - 1));
	assign commit = (state_reg == ST_SAVE) && p_menu && yes_reg;
	assign revert = timeout_hit ||
		((state_reg == ST_SAVE) && p_menu && !yes_reg);
	assign reg_wr = WR && (state_reg == ST_NORMAL);
	assign tx_start = WR && (ADDR == `OFS_UART) && !tx_busy;

	// =================================================================
	// Main state machine, power-up steps then menu
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_reg     <= ST_PU_SEGMENTS;
			phase_cnt_reg <= 30'h00000000;
		end else if (CE) begin
			case (state_reg)
				ST_PU_SEGMENTS, ST_PU_MODEL, ST_PU_STATUS: begin
					if (phase_cnt_reg == 30'(PHASE_CYCLES - 1)) begin
						phase_cnt_reg <= 30'h00000000;
						state_reg <= ctrl_state_type'(state_reg +
							3'b001);
					end else begin
						phase_cnt_reg <= phase_cnt_reg + 30'h00000001;
					end
				end
				ST_NORMAL: begin
					if (p_menu) state_reg <= ST_EDIT;
				end
				ST_EDIT: begin
					if (timeout_hit) begin
						state_reg <= ST_NORMAL;
					end else if (p_menu && (cursor_reg == `CUR_RET ||
						menu_reg == `MENU_LAST)) begin
						state_reg <= ST_SAVE;
					end
				end
				ST_SAVE: begin
					if (p_menu || timeout_hit) state_reg <= ST_NORMAL;
				end
				default: state_reg <= ST_NORMAL;
			endcase
		end
	end

	// Idle counter; restarts on every switch action
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			idle_cnt_reg <= 30'h00000000;
		end else if (CE) begin
			if (any_press || timeout_hit ||
				(state_reg != ST_EDIT && state_reg != ST_SAVE))
				idle_cnt_reg <= 30'h00000000;
			else
				idle_cnt_reg <= idle_cnt_reg + 30'h00000001;
		end
	end

	// Menu number, cursor and yes/no choice
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			menu_reg   <= 3'h1;
			cursor_reg <= 3'h0;
			yes_reg    <= 1'b1;
		end else if (CE) begin
			if (state_reg == ST_NORMAL && p_menu) begin
				menu_reg   <= 3'h1;
				cursor_reg <= 3'h0;
			end else if (state_reg == ST_EDIT) begin
				if (p_menu) begin
					menu_reg   <= menu_reg + 3'h1;
					cursor_reg <= 3'h0;
					yes_reg    <= 1'b1;
				end else if (p_left && cursor_reg != 3'h0) begin
					cursor_reg <= cursor_reg - 3'h1;
				end else if (p_right && cursor_reg != `CUR_RET) begin
					cursor_reg <= cursor_reg + 3'h1;
				end
			end else if (state_reg == ST_SAVE && p_vert) begin
				yes_reg <= ~yes_reg;
			end
		end
	end

	// =================================================================
	// Working copy: what the panel edits; gain drives the path live
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			work_reg <= RST_SETTINGS;
		end else if (CE) begin
			if (nv_load) begin
				work_reg <= nv_image;
			end else if (revert) begin
				work_reg <= saved_reg;
			end else if (reg_wr) begin
				work_reg <= reg_write(saved_reg, ADDR, WDATA);
			end else if (state_reg == ST_EDIT && p_vert &&
				!p_menu && cursor_reg != `CUR_RET) begin
				work_reg <= edit_item(work_reg, menu_reg, cursor_reg,
					p_up);
			end
		end
	end

	// Stored copy; only the power-up load, a confirmed save or a remote write changes it
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			saved_reg  <= RST_SETTINGS;
			loaded_reg <= 1'b0;
			NV_STORE   <= 1'b0;
			NV_OUT     <= 32'h00000000;
		end else if (CE) begin
			NV_STORE <= 1'b0;
			if (nv_load) begin
				saved_reg  <= nv_image;
				loaded_reg <= 1'b1;
			end else if (commit) begin
				saved_reg <= work_reg;
				NV_OUT    <= {3'h0, work_reg};
				NV_STORE  <= 1'b1;
			end else if (reg_wr && ADDR != `OFS_UART) begin
				saved_reg <= reg_write(saved_reg, ADDR, WDATA);
				NV_OUT    <= {3'h0, reg_write(saved_reg, ADDR, WDATA)};
				NV_STORE  <= 1'b1;
			end
		end
	end

	// Applied settings; only gain follows the edit before saving
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			GAIN         <= `RST_GAIN;
			MUTE         <= 1'b0;
			REF_OFFSET   <= `RST_OFFSET;
			REMOTE_IFACE <= 1'b0;
			BUS_ADDR     <= `RST_ADDR;
			REMOTE_LED   <= 1'b0;
		end else if (CE) begin
			GAIN         <= work_reg.gain;
			MUTE         <= saved_reg.mute;
			REF_OFFSET   <= saved_reg.offset;
			REMOTE_IFACE <= saved_reg.iface;
			BUS_ADDR     <= saved_reg.addr;
			REMOTE_LED   <= saved_reg.remote;
		end
	end

	// =================================================================
	// Reference selection; auto holds its choice between thresholds
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			REF_USE_EXT                    <= 1'b0;
			REFERENCE_OUTPUT_CONNECTOR_EXT <= 1'b0;
			DISP_REF                       <= IND_INT;
		end else if (CE) begin
			case (ref_mode_type'(saved_reg.ref_mode))
				REF_EXT: begin
					REF_USE_EXT                    <= 1'b1;
					REFERENCE_OUTPUT_CONNECTOR_EXT <= 1'b1;
					DISP_REF                       <= IND_EXT;
				end
				REF_AUTO: begin
					if (pin_level[0]) begin
						REF_USE_EXT <= 1'b0;
						REFERENCE_OUTPUT_CONNECTOR_EXT <= 1'b0;
						DISP_REF <= IND_AUTO_I;
					end else if (pin_level[1]) begin
						REF_USE_EXT <= 1'b1;
						REFERENCE_OUTPUT_CONNECTOR_EXT <= 1'b1;
						DISP_REF <= IND_AUTO_E;
					end
				end
				default: begin
					REF_USE_EXT                    <= 1'b0;
					REFERENCE_OUTPUT_CONNECTOR_EXT <= 1'b0;
					DISP_REF                       <= IND_INT;
				end
			endcase
		end
	end

	// Alarm and power indicators
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ALARM_INDICATOR_LED    <= 1'b0;
			ALARM_RELAY            <= 1'b0;
			DC_POWER_INDICATOR_LED <= 1'b0;
		end else if (CE) begin
			ALARM_INDICATOR_LED    <= ~&pin_level[3:2];
			ALARM_RELAY            <= ~&pin_level[3:2];
			DC_POWER_INDICATOR_LED <= 1'b1;
		end
	end

	// =================================================================
	// Display page, cursor and save choice
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			DISP_PAGE   <= PG_ALL_ON;
			DISP_CURSOR <= 3'h0;
			DISP_YES    <= 1'b0;
		end else if (CE) begin
			DISP_CURSOR <= cursor_reg;
			DISP_YES    <= yes_reg;
			case (state_reg)
				ST_PU_SEGMENTS: DISP_PAGE <= PG_ALL_ON;
				ST_PU_MODEL:    DISP_PAGE <= PG_MODEL;
				ST_EDIT:  DISP_PAGE <= disp_page_type'({1'b0, menu_reg});
				ST_SAVE:  DISP_PAGE <= PG_SAVE;
				default:  DISP_PAGE <= PG_STATUS;
			endcase
		end
	end

	// =================================================================
	// Register read port, data in the cycle after the strobe only
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 32'h00000000;
		end else if (CE) begin
			RDATA <= 32'h00000000;
			if (RD) begin
				if (ADDR == `OFS_STATUS)
					RDATA <= {24'h000000, tx_busy,
						state_reg == ST_EDIT || state_reg == ST_SAVE,
						3'(state_reg), 1'b0, ALARM_RELAY, REF_USE_EXT};
				else if (ADDR == `OFS_GAIN)
					RDATA <= {25'h0000000, saved_reg.gain};
				else if (ADDR == `OFS_CONTROL)
					RDATA <= {27'h0000000, saved_reg.iface,
						saved_reg.remote, saved_reg.ref_mode,
						saved_reg.mute};
				else if (ADDR == `OFS_OFFSET)
					RDATA <= {{20{saved_reg.offset[11]}},
						saved_reg.offset};
				else if (ADDR == `OFS_BUSADDR)
					RDATA <= {27'h0000000, saved_reg.addr};
				else if (ADDR == `OFS_UART)
					RDATA <= {31'h00000000, tx_busy};
			end
		end
	end

	// Remote serial link transmitter
	serial_tx u_tx (
		.clk   (CLK),
		.reset (RESET),
		.ce    (CE),
		.start (tx_start),
		.data  (WDATA[7:0]),
		.txd   (SER_TXD),
		.busy  (tx_busy)
	);

endmodule
`default_nettype wire

// ---- verification/panel_ctrl_monitor.sv ----
/*
 Port checker of panel_ctrl.
 Assumes one clock and CE held high.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_ctrl_monitor
	import fpsc_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 1,
	parameter int unsigned PHASE_CYCLES   = 1
) (
	input wire logic                    CLK,
	input wire logic                    RESET,
	input wire logic [1:0]              PLL_LOCK,
	input wire logic                    WR,
	input wire logic                    RD,
	input wire logic [31:0]             RDATA,
	input wire logic                    NV_STORE,
	input wire logic                    REF_USE_EXT,
	input wire logic                    REFERENCE_OUTPUT_CONNECTOR_EXT,
	input wire fpsc_pkg::ref_ind_type   DISP_REF,
	input wire fpsc_pkg::disp_page_type DISP_PAGE,
	input wire logic                    ALARM_INDICATOR_LED,
	input wire logic                    ALARM_RELAY
);
	import fpsc_pkg::*;
	// ====================
	// Properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// Eight cycles cover the synchroniser plus the output flop
	property p_alarm_on; !(&PLL_LOCK) [*8] |-> ALARM_INDICATOR_LED; endproperty
	property p_alarm_off; (&PLL_LOCK) [*8] |-> !ALARM_INDICATOR_LED; endproperty
	property p_relay; ALARM_RELAY == ALARM_INDICATOR_LED; endproperty
	property p_refout; REFERENCE_OUTPUT_CONNECTOR_EXT == REF_USE_EXT; endproperty
	property p_refind;
		REF_USE_EXT == (DISP_REF inside {IND_EXT, IND_AUTO_E});
	endproperty
	property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
	// A store only follows a remote write or a cycle on the save prompt page
	property p_store;
		NV_STORE |-> $past(WR) || $past(DISP_PAGE) == PG_SAVE;
	endproperty
	// Model page may only follow the all-segments page
	property p_pu_order;
		(DISP_PAGE == PG_MODEL && $past(DISP_PAGE) != PG_MODEL)
			|-> $past(DISP_PAGE) == PG_ALL_ON;
	endproperty
	a_alarm_on: assert property (p_alarm_on) else $error("no alarm");
	a_alarm_off: assert property (p_alarm_off) else $error("alarm");
	a_relay: assert property (p_relay) else $error("relay");
	a_refout: assert property (p_refout) else $error("ref out");
	a_refind: assert property (p_refind) else $error("ref ind");
	a_rd_idle: assert property (p_rd_idle) else $error("rdata");
	a_store: assert property (p_store) else $error("store");
	a_pu_order: assert property (p_pu_order) else $error("pu");
	c_store: cover property (NV_STORE);
	c_save: cover property (DISP_PAGE == PG_SAVE);
	c_auto_i: cover property (DISP_REF == IND_AUTO_I);
endmodule
bind panel_ctrl panel_ctrl_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.PHASE_CYCLES(PHASE_CYCLES)) panel_ctrl_monitor_i (.*);
`default_nettype wire

// ---- verification/panel_model.sv ----
/*
 Operator switch model: 0 menu, 1 left, 2 right, 3 up, 4 down.
 Assumes presses are called by name from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_model (
	input  wire logic       clk,
	output var  logic [4:0] sw
);
	// ====================
	// Switches
	initial sw = 5'h00;
	// Held past the synchroniser, then released so the next counts
	task automatic press(input int k);
		@(posedge clk);
		sw[k] <= 1'b1;
		repeat (6) @(posedge clk);
		sw[k] <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
/*
 Bench of panel_ctrl: bus tasks, switch presses, reference table.
 Assumes fpsc_pkg, panel_model and the monitor compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fpsc_pkg::*;
	logic CLK = 0, RESET = 1, CE = 1, WR = 0, RD = 0;
	logic REF_LVL_OK = 0, REF_LVL_LOW = 0, NV_IN_VALID = 0;
	logic [1:0] PLL_LOCK = 2'h3;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0, NV_IN = 32'h0, RDATA, NV_OUT;
	wire logic MENU_SW, LEFT_SW, RIGHT_SW, UP_SW, DOWN_SW;
	wire logic [4:0] sw;
	logic NV_STORE, MUTE, REMOTE_IFACE, REF_USE_EXT, DISP_YES, SER_TXD;
	logic REFERENCE_OUTPUT_CONNECTOR_EXT, REMOTE_LED, DC_POWER_INDICATOR_LED;
	logic ALARM_INDICATOR_LED, ALARM_RELAY;
	logic [6:0] GAIN;
	logic [11:0] REF_OFFSET;
	logic [4:0] BUS_ADDR;
	logic [2:0] DISP_CURSOR;
	ref_ind_type DISP_REF;
	disp_page_type DISP_PAGE;
	logic [1:0] mode [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	ref_ind_type ind [4] = '{IND_INT, IND_EXT, IND_AUTO_I, IND_AUTO_E};
	int mismatches = 0, n_checks = 0, cyc = 0;
	assign {DOWN_SW, UP_SW, RIGHT_SW, LEFT_SW, MENU_SW} = sw;
	// Short counts keep the run small
	panel_ctrl #(.TIMEOUT_CYCLES(200), .PHASE_CYCLES(10)) panel_ctrl_i (.*);
	panel_model panel_model_i (.clk(CLK), .sw(sw));
	// ====================
	// Clock and watchdog
	initial begin
		forever #20 CLK = ~CLK;
	end
	// Whole sequence needs about 3600 cycles
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	// ====================
	// Tasks
	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk("rdata", e, RDATA);
	endtask
	task automatic hit(input int k, input int n);
		repeat (n) panel_model_i.press(k);
	endtask
	// Reset for four cycles, then wait out the power-up pages
	task automatic boot();
		RESET <= 1'b1;
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		repeat (45) @(posedge CLK);
	endtask
	// ====================
	// Sequence
	initial begin
		boot();
		chk("gain", 32'h28, GAIN);
		chk("page", PG_STATUS, DISP_PAGE);
		rd(8'h40, 32'h0);
		wr(8'h04, 32'h30);
		rd(8'h04, 32'h30);
		hit(0, 1);
		chk("page", PG_GAIN, DISP_PAGE);
		hit(3, 1);
		chk("gain", 32'h44, GAIN);
		hit(2, 1);
		chk("cursor", 32'h1, DISP_CURSOR);
		hit(4, 1);
		chk("gain", 32'h42, GAIN);
		hit(1, 1);
		chk("cursor", 32'h0, DISP_CURSOR);
		hit(2, 4);
		hit(0, 1);
		chk("page", PG_SAVE, DISP_PAGE);
		hit(4, 1);
		chk("yes", 32'h0, DISP_YES);
		hit(0, 1);
		chk("gain", 32'h30, GAIN);
		hit(0, 1);
		hit(3, 1);
		repeat (230) @(posedge CLK);
		chk("gain", 32'h30, GAIN);
		chk("page", PG_STATUS, DISP_PAGE);
		hit(0, 1);
		hit(3, 1);
		hit(2, 4);
		hit(0, 2);
		rd(8'h04, 32'h44);
		NV_IN <= NV_OUT;
		NV_IN_VALID <= 1'b1;
		boot();
		chk("gain", 32'h44, GAIN);
		hit(0, 2);
		hit(3, 1);
		chk("mute", 32'h0, MUTE);
		hit(2, 4);
		hit(0, 2);
		chk("mute", 32'h1, MUTE);
		for (int i = 0; i < 4; i++) begin
			REF_LVL_LOW <= (i == 1 || i == 2);
			REF_LVL_OK <= (i == 3);
			wr(8'h08, {28'h0, i[0], mode[i], 1'b0});
			repeat (6) @(posedge CLK);
			chk("ext", i[0], REF_USE_EXT);
			chk("ind", ind[i], DISP_REF);
			chk("remote", i[0], REMOTE_LED);
		end
		wr(8'h14, 32'hA5);
		chk("txd", 32'h0, SER_TXD);
		rd(8'h14, 32'h1);
		repeat (2700) @(posedge CLK);
		chk("txd", 32'h1, SER_TXD);
		PLL_LOCK <= 2'h2;
		repeat (8) @(posedge CLK);
		chk("alarm", 32'h1, ALARM_INDICATOR_LED);
		chk("relay", 32'h1, ALARM_RELAY);
		PLL_LOCK <= 2'h3;
		repeat (8) @(posedge CLK);
		chk("alarm", 32'h0, ALARM_INDICATOR_LED);
		print_verdict();
	end
endmodule
`default_nettype wire
